//--- bench/rss_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module rss_pin_model (
	input wire logic pin_out,
	input wire logic pin_oe,
	input wire logic drive_en,
	input wire logic drive_lvl,
	output logic pin
);
	// pull-up: a released pin reads high, the idle level while pol is clear
	always_comb begin
		if (pin_oe)
			pin = pin_out;
		else if (drive_en)
			pin = drive_lvl;
		else
			pin = 1'b1;
	end
endmodule
`default_nettype wire

//--- bench/rss_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rss_top_tb_top;
	localparam logic [6:0] CFG = rss_pkg::ADR_CONFIG;
	logic clk = 1'b0;
	logic reset = 1'b1;
	rss_pkg::rss_wr_s wr = '0;
	logic [6:0] rd_addr = 7'h00;
	logic [31:0] rd_data;
	rss_pkg::rss_evt_s evt = '0;
	logic pin, pin_out, pin_oe, stv, shl, busy;
	logic drv_en = 1'b0;
	logic drv_lvl = 1'b1;
	rss_pkg::rss_param_s param;
	logic [6:0] pa [4] = '{rss_pkg::ADR_TARGET, rss_pkg::ADR_MAX_VELOCITY,
		rss_pkg::ADR_RAMP_PROFILE_MODE, rss_pkg::ADR_GEAR};
	int n_mismatch = 0;
	int comparisons = 0;
	always #50 clk = ~clk;
	rss_top rss_top_inst (.clk(clk), .reset(reset), .wr(wr),
		.rd_addr(rd_addr), .rd_data(rd_data), .evt(evt),
		.start_pin_in(pin), .start_pin_out(pin_out),
		.start_pin_oe(pin_oe), .start_signal(stv),
		.shadow_load(shl), .timer_busy(busy), .param(param));
	rss_pin_model rss_pin_model_inst (.pin_out(pin_out), .pin_oe(pin_oe),
		.drive_en(drv_en), .drive_lvl(drv_lvl), .pin(pin));
	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic wreg(input logic [6:0] a, input logic [31:0] d);
		@(negedge clk);
		wr = '{1'b1, a, d};
		@(negedge clk);
		wr = '0;
	endtask
	task automatic rchk(input logic [6:0] a, input logic [31:0] e);
		@(negedge clk);
		rd_addr = a;
		@(negedge clk);
		chk(rd_data === e, "read back");
	endtask
	// bounded wait; 0 means no start seen
	task automatic wstart(output int k);
		k = 0;
		for (int i = 1; i <= 40 && k == 0; i++) begin
			@(negedge clk);
			if (stv === 1'b1)
				k = i;
		end
	endtask
	task automatic fire(input logic [2:0] e, output int k);
		@(negedge clk);
		evt = rss_pkg::rss_evt_s'(e);
		wstart(k);
	endtask
	// events stay high meanwhile, so a level must not restart
	task automatic count(input int c, output int s);
		s = 0;
		repeat (c) begin
			@(negedge clk);
			if (stv === 1'b1)
				s++;
		end
		evt = '0;
	endtask
	function automatic logic [31:0] pv(int i);
		case (i)
			0: return param.target_position;
			1: return param.max_velocity;
			2: return {29'h0, param.ramp_profile_mode};
			default: return param.step_scaling_factor;
		endcase
	endfunction
	task automatic t_off;
		int k, s;
		chk(pin_oe === 1'b1 && pin_out === 1'b1 &&
			param === '0, "rst");
		rchk(CFG, 32'h0);
		rchk(7'h7f, 32'h0);
		fire(3'h7, k);
		count(2, s);
		chk(k == 0, "start with field zero");
	endtask
	task automatic t_src;
		int k, s;
		for (int b = 0; b < 3; b++) begin
			wreg(CFG, 32'h40 << b);
			fire(3'h7 ^ (3'h1 << b), k);
			count(2, s);
			chk(k == 0, "unselected source");
			fire(3'h1 << b, k);
			count(2, s);
			chk(k >= 2 && k <= 3, "source");
		end
		wreg(CFG, 32'h1c0);
		rchk(CFG, 32'h1c0);
		fire(3'h7, k);
		chk(shl === 1'b0, "shadow without enable");
		count(12, s);
		chk(k != 0 && s == 0, "joint trigger");
	endtask
	task automatic t_delay;
		int k0, k5, s;
		wreg(CFG, 32'h40);
		fire(3'h1, k0);
		count(2, s);
		wreg(rss_pkg::ADR_DELAY, 32'h5);
		rchk(rss_pkg::ADR_DELAY, 32'h5);
		@(negedge clk);
		evt = 3'h1;
		@(negedge clk);
		chk(busy === 1'b1, "timer not running");
		// one edge already spent on the busy check
		wstart(k5);
		k5++;
		count(12, s);
		chk(k0 != 0 && k5 - k0 == 5, "delay");
		chk(s == 0 && busy === 1'b0, "level restart");
		wreg(rss_pkg::ADR_DELAY, 32'h0);
	endtask
	task automatic t_pulse;
		int k, n;
		wreg(rss_pkg::ADR_OUT_ADD, 32'h3);
		for (int p = 0; p < 2; p++) begin
			wreg(CFG, 32'h40 | (p << 9));
			chk(pin_oe === 1'b1 && pin === 1'(p == 0), "idle");
			fire(3'h1, k);
			n = 0;
			repeat (10) begin
				@(negedge clk);
				if (pin === 1'(p != 0))
					n++;
			end
			evt = '0;
			chk(n == 4, "pulse");
		end
		wreg(rss_pkg::ADR_OUT_ADD, 32'h0);
	endtask
	task automatic t_ext;
		int k, s;
		for (int p = 0; p < 2; p++) begin
			wreg(CFG, 32'h20 | (p << 9));
			chk(pin_oe === 1'b0, "pin not input");
			drv_lvl = 1'(p == 0);
			drv_en = 1'b1;
			repeat (4) @(negedge clk);
			drv_lvl = 1'(p != 0);
			wstart(k);
			count(12, s);
			chk(k >= 4 && k <= 7 && s == 0, "pin edge");
			drv_lvl = 1'b1;
			drv_en = 1'b0;
			// let the release settle before polarity flips
			repeat (4) @(negedge clk);
		end
	endtask
	task automatic t_defer;
		int k, s;
		for (int i = 0; i < 4; i++) begin
			wreg(CFG, 32'h40);
			wreg(pa[i], 32'(i + 1));
			chk(pv(i) === 32'(i + 1), "direct");
			wreg(CFG, 32'h50 | (32'h1 << i));
			wreg(pa[i], 32'(i + 2));
			wreg(pa[i], 32'(i + 3));
			wreg(pa[(i + 1) % 4], 32'h6);
			chk(pv(i) === 32'(i + 1), "held");
			chk(pv((i + 1) % 4) === 32'h6, "other");
			rchk(rss_pkg::ADR_STATUS, 32'h4 << i);
			fire(3'h1, k);
			chk(shl === 1'b1, "shadow");
			count(3, s);
			chk(pv(i) === 32'(i + 3), "latest");
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// whole run is a few hundred cycles
	initial begin
		#2000000;
		n_mismatch++;
		results;
	end
	initial begin
		repeat (6) @(negedge clk);
		reset = 1'b0;
		t_off;
		t_src;
		t_delay;
		t_pulse;
		t_ext;
		t_defer;
		results;
	end
endmodule
`default_nettype wire

//--- logic/rss_pkg.sv
`default_nettype none
package rss_pkg;
	localparam logic [6:0] ADR_CONFIG = 7'h02;
	localparam logic [6:0] ADR_OUT_ADD = 7'h11;
	localparam logic [6:0] ADR_DELAY = 7'h13;
	localparam logic [6:0] ADR_TARGET = 7'h30;
	localparam logic [6:0] ADR_MAX_VELOCITY = 7'h31;
	localparam logic [6:0] ADR_RAMP_PROFILE_MODE = 7'h32;
	localparam logic [6:0] ADR_GEAR = 7'h33;
	localparam logic [6:0] ADR_STATUS = 7'h34;
	localparam int EN_LO = 0;
	localparam int EN_SHADOW = 4;
	localparam int TRIG_LO = 5;
	localparam int TRIG_EXT = 5;
	localparam int POL_BIT = 9;
	localparam int NPAR = 4;
	localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
	localparam logic [31:0] OUT_ADD_RST = 32'h0000_0000;
	localparam logic [31:0] DELAY_RST = 32'h0000_0000;
	localparam logic [31:0] PARAM_RST = 32'h0000_0000;
	localparam logic [31:0] MODE_MASK = 32'h0000_0007;
	localparam logic [2:0] SYNC_RST = 3'h7;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} rss_state_e;
	typedef struct packed {
		logic valid;
		logic [6:0] addr;
		logic [31:0] data;
	} rss_wr_s;
	typedef struct packed {
		logic position_compare_event;
		logic velocity_reached;
		logic target_reached;
	} rss_evt_s;
	typedef struct packed {
		logic [31:0] target_position;
		logic [31:0] max_velocity;
		logic [2:0] ramp_profile_mode;
		logic [31:0] step_scaling_factor;
	} rss_param_s;
	typedef struct packed {
		rss_state_e st;
		logic [31:0] cfg;
		logic [31:0] out_add;
		logic [31:0] delay;
		logic [31:0] dcnt;
		logic [31:0] ocnt;
		logic out_on;
		logic start;
		logic [2:0] pin_sync;
		logic pin_lvl;
		logic [2:0] ev_prev;
		logic [NPAR-1:0][31:0] act;
		logic [NPAR-1:0][31:0] pend;
		logic [NPAR-1:0] pflag;
		logic [31:0] rd_data;
	} rss_state_s;
	// parameter index 0..3 follows the start_en bit order
	function automatic logic [6:0] par_addr(input int i);
		case (i)
			0: return ADR_TARGET;
			1: return ADR_MAX_VELOCITY;
			2: return ADR_RAMP_PROFILE_MODE;
			default: return ADR_GEAR;
		endcase
	endfunction
	function automatic logic [31:0] par_mask(input int i);
		return (i == 2) ? MODE_MASK : 32'hffff_ffff;
	endfunction
endpackage
`default_nettype wire

//--- logic/rss_top.sv
// Contract
// - trigger is an edge, not start
// - trigger plus delay gives one start
// - trigger field zero disables starts
// - bit0 clear: start pin drives output
// - bit0 set: filtered pin edge triggers
// - bit1 enables target reached trigger
// - bit2 enables velocity reached trigger
// - bit3 enables position compare trigger
// - trigger sources combine independently
// - undeferred writes apply at once
// - start_en0 defers target position
// - start_en1 defers maximum velocity
// - start_en2 defers ramp profile mode
// - start_en3 defers step scaling factor
// - start_en4 loads shadow set on start
// - deferral bits act independently
// - start follows trigger after delay plus two cycles
// - start pin active low unless inverted
// - output pulse lasts one plus extension
`timescale 1ns/1ps
`default_nettype none
module rss_top (
	input wire logic clk,
	input wire logic reset,
	input wire rss_pkg::rss_wr_s wr,
	input wire logic [6:0] rd_addr,
	output logic [31:0] rd_data,
	input wire rss_pkg::rss_evt_s evt,
	input wire logic start_pin_in,
	output logic start_pin_out,
	output logic start_pin_oe,
	output logic start_signal,
	output logic shadow_load,
	output logic timer_busy,
	output rss_pkg::rss_param_s param
);
	rss_pkg::rss_state_s s;
	rss_pkg::rss_state_s next_s;
	logic [3:0] trig;
	logic pol;
	logic [2:0] ev_now;
	logic [2:0] ev_rise;
	logic pin_agree;
	logic ext_edge;
	logic fire_int;
	logic fire_ext;
	logic fire;

	assign trig = s.cfg[rss_pkg::TRIG_LO +: 4];
	assign pol = s.cfg[rss_pkg::POL_BIT];
	assign ev_now = {evt.position_compare_event, evt.velocity_reached,
		evt.target_reached};

	// only the rising edge of an event counts as a trigger
	assign ev_rise = ev_now & ~s.ev_prev;

	// second and third stage agree before a change counts
	assign pin_agree = (s.pin_sync[1] == s.pin_sync[2]);

	// edge into the active level; pol clear means high to low
	assign ext_edge = pin_agree && (s.pin_sync[2] != s.pin_lvl) &&
		(s.pin_sync[2] == pol);

	// each source gated by its own select bit
	assign fire_int = |(ev_rise & trig[3:1]);

	// pin edges only count while the pin is an input
	assign fire_ext = trig[0] && ext_edge;

	// simultaneous triggers merge into one timing process
	assign fire = fire_int || fire_ext;

	always_comb begin
		next_s = s;
		next_s.start = 1'b0;
		next_s.pin_sync = {s.pin_sync[1:0], start_pin_in};
		if (pin_agree) begin
			next_s.pin_lvl = s.pin_sync[2];
		end
		next_s.ev_prev = ev_now;

		// delay timer; triggers during a wait are ignored
		unique case (s.st)
			rss_pkg::ST_IDLE: begin
				if (fire) begin
					next_s.st = rss_pkg::ST_WAIT;
					next_s.dcnt = s.delay;
				end
			end
			rss_pkg::ST_WAIT: begin
				if (s.dcnt == 32'h0000_0000) begin
					next_s.st = rss_pkg::ST_IDLE;
					// no start while trigger field is zero
					next_s.start = (trig != 4'h0);
				end else begin
					next_s.dcnt = s.dcnt - 32'h0000_0001;
				end
			end
			default: begin
				next_s.st = rss_pkg::ST_IDLE;
			end
		endcase

		// pin pulse: one cycle plus extension
		if (s.start) begin
			next_s.out_on = 1'b1;
			next_s.ocnt = s.out_add;
		end else if (s.out_on) begin
			if (s.ocnt == 32'h0000_0000) begin
				next_s.out_on = 1'b0;
			end else begin
				next_s.ocnt = s.ocnt - 32'h0000_0001;
			end
		end

		for (int i = 0; i < rss_pkg::NPAR; i++) begin
			// pending value moves on start
			if (s.start && s.pflag[i]) begin
				next_s.act[i] = s.pend[i];
				next_s.pflag[i] = 1'b0;
			end
			// a write in the start cycle stays pending: set wins
			if (wr.valid && wr.addr == rss_pkg::par_addr(i)) begin
				// bit i defers parameter i alone
				if (s.cfg[rss_pkg::EN_LO + i]) begin
					next_s.pend[i] = wr.data & rss_pkg::par_mask(i);
					next_s.pflag[i] = 1'b1;
				end else begin
					next_s.act[i] = wr.data & rss_pkg::par_mask(i);
				end
			end
		end

		if (wr.valid) begin
			unique case (wr.addr)
				rss_pkg::ADR_CONFIG: begin
					next_s.cfg = wr.data;
				end
				rss_pkg::ADR_OUT_ADD: begin
					next_s.out_add = wr.data;
				end
				rss_pkg::ADR_DELAY: begin
					next_s.delay = wr.data;
				end
				default: begin
				end
			endcase
		end

		// read data registered; unmapped addresses read zero
		unique case (rd_addr)
			rss_pkg::ADR_CONFIG: begin
				next_s.rd_data = s.cfg;
			end
			rss_pkg::ADR_OUT_ADD: begin
				next_s.rd_data = s.out_add;
			end
			rss_pkg::ADR_DELAY: begin
				next_s.rd_data = s.delay;
			end
			rss_pkg::ADR_TARGET: begin
				next_s.rd_data = s.act[0];
			end
			rss_pkg::ADR_MAX_VELOCITY: begin
				next_s.rd_data = s.act[1];
			end
			rss_pkg::ADR_RAMP_PROFILE_MODE: begin
				next_s.rd_data = s.act[2];
			end
			rss_pkg::ADR_GEAR: begin
				next_s.rd_data = s.act[3];
			end
			rss_pkg::ADR_STATUS: begin
				next_s.rd_data = {26'h000_0000, s.pflag,
					s.st == rss_pkg::ST_WAIT, s.out_on};
			end
			default: begin
				next_s.rd_data = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '{st: rss_pkg::ST_IDLE,
				cfg: rss_pkg::CONFIG_RST,
				out_add: rss_pkg::OUT_ADD_RST,
				delay: rss_pkg::DELAY_RST,
				pin_sync: rss_pkg::SYNC_RST,
				pin_lvl: 1'b1,
				act: {rss_pkg::NPAR{rss_pkg::PARAM_RST}},
				default: '0};
		end else begin
			s <= next_s;
		end
	end

	assign rd_data = s.rd_data;
	assign start_signal = s.start;
	// shadow set load follows each start when enabled
	assign shadow_load = s.start && s.cfg[rss_pkg::EN_SHADOW];
	assign timer_busy = (s.st == rss_pkg::ST_WAIT);
	// pin driven as output only while external trigger is off
	assign start_pin_oe = ~s.cfg[rss_pkg::TRIG_EXT];
	// idle level is the inverse of the active level
	assign start_pin_out = s.out_on ? pol : ~pol;
	assign param.target_position = s.act[0];
	assign param.max_velocity = s.act[1];
	assign param.ramp_profile_mode = s.act[2][2:0];
	assign param.step_scaling_factor = s.act[3];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_trig_off_quiet: assert property (
		trig == 4'h0 |=> !start_signal)
		else $error("start produced with trigger field zero");

	a_pin_out_pulse: assert property (
		start_signal && !s.cfg[rss_pkg::TRIG_EXT] |=>
		start_pin_oe && start_pin_out == pol)
		else $error("start not forwarded to output pin");

	a_pin_in_mode: assert property (
		s.cfg[rss_pkg::TRIG_EXT] |-> !start_pin_oe)
		else $error("pin driven while used as input");

	a_event_arms: assert property (
		s.st == rss_pkg::ST_IDLE && trig[1] && evt.target_reached &&
		!s.ev_prev[0] |=> s.st == rss_pkg::ST_WAIT)
		else $error("target reached edge did not arm timer");

	a_zero_delay: assert property (
		fire && s.st == rss_pkg::ST_IDLE && s.delay == 32'h0000_0000 &&
		!wr.valid ##1 trig != 4'h0 |=> start_signal)
		else $error("zero delay start not two cycles after trigger");

	a_pulse_ends: assert property (
		s.out_on && s.ocnt == 32'h0000_0000 && !start_signal |=>
		!s.out_on)
		else $error("output pulse longer than programmed");

	a_defer_apply: assert property (
		start_signal && s.pflag[0] && !(wr.valid &&
		wr.addr == rss_pkg::ADR_TARGET) |=>
		param.target_position == $past(s.pend[0]) && !s.pflag[0])
		else $error("pending target not applied on start");

	a_direct_write: assert property (
		wr.valid && wr.addr == rss_pkg::ADR_MAX_VELOCITY &&
		!s.cfg[rss_pkg::EN_LO + 1] |=>
		param.max_velocity == $past(wr.data))
		else $error("undeferred velocity write not applied");

	// a start in the write cycle may still apply an older pending value
	a_defer_hold: assert property (
		wr.valid && wr.addr == rss_pkg::ADR_MAX_VELOCITY &&
		s.cfg[rss_pkg::EN_LO + 1] |=>
		s.pflag[1] && param.max_velocity ==
		($past(start_signal && s.pflag[1]) ? $past(s.pend[1]) :
		$past(param.max_velocity)))
		else $error("deferred velocity write applied early");

	a_one_start: assert property (
		start_signal |=> !start_signal)
		else $error("start signal longer than one cycle");

	a_pend_latest: assert property (
		wr.valid && wr.addr == rss_pkg::ADR_TARGET &&
		s.cfg[rss_pkg::EN_LO] |=>
		s.pflag[0] && s.pend[0] == $past(wr.data))
		else $error("pending target not replaced by latest write");

	a_mode_hold: assert property (
		wr.valid && wr.addr == rss_pkg::ADR_RAMP_PROFILE_MODE &&
		s.cfg[rss_pkg::EN_LO + 2] && !start_signal |=>
		$stable(param.ramp_profile_mode) && s.pflag[2])
		else $error("deferred ramp mode write applied early");

	a_gear_hold: assert property (
		wr.valid && wr.addr == rss_pkg::ADR_GEAR &&
		s.cfg[rss_pkg::EN_LO + 3] && !start_signal |=>
		$stable(param.step_scaling_factor) && s.pflag[3])
		else $error("deferred scaling write applied early");

	// stage two holds the pin two ticks back, stage three three ticks back
	a_ext_filter: assert property (
		ext_edge |-> $past(start_pin_in, 2) == $past(start_pin_in, 3) &&
		$past(start_pin_in, 2) == pol)
		else $error("pin edge taken before filter agreed");

	a_off_no_timer: assert property (
		trig == 4'h0 && !timer_busy |=> !timer_busy)
		else $error("timer started with trigger field zero");

	c_ext_start: cover property (
		fire_ext ##[1:20] start_signal);
	c_multi_trig: cover property (
		fire_int && fire_ext);
	c_pending_load: cover property (
		start_signal && s.pflag[0] && s.pflag[1]);
	c_delayed_start: cover property (
		timer_busy ##1 timer_busy ##1 timer_busy ##1 start_signal);
endmodule
`default_nettype wire
